/* File: sdf_map.vh */
// sdf_map.vh: constants for the decimation rate controller
// assumes inclusion by bare name from each design file
`ifndef SDF_MAP_VH
`define SDF_MAP_VH
`define SDF_RATE_W      10
`define SDF_DEC_BASE    20'h00400
`define SDF_DEC_W       20
`define SDF_CNT_W       32
`define SDF_RATE_MIN    10'h001
`define SDF_NOTCH_RATE  10'h060
`define SDF_ORDER3      3'h3
`define SDF_ORDER4      3'h4
`define SDF_DATA_W      24
`define SDF_ACC_W       32
`define SDF_ZERO_LAT_BIT 11
`define SDF_MODE_W      12
`endif

/* File: sdf_period_div.v */
// sdf_period_div.v: down-counter giving a one-cycle tick every n master clocks
// assumes n is stable between restarts; restart reloads the count
`timescale 1ns/1ns
`include "sdf_map.vh"
module sdf_period_div (
    input  wire                  mclk_in,
    input  wire                  arst_n_in,
    input  wire                  restart_in,
    input  wire [`SDF_CNT_W-1:0] period_in,
    output reg                   tick_out
);
    reg [`SDF_CNT_W-1:0] cnt_q;
    // count down; a reload on restart keeps the first period whole
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_q    <= {`SDF_CNT_W{1'b0}};
            tick_out <= 1'b0;
        end else if (restart_in) begin
            cnt_q    <= period_in - {{(`SDF_CNT_W-1){1'b0}}, 1'b1};
            tick_out <= 1'b0;
        end else if (cnt_q == {`SDF_CNT_W{1'b0}}) begin
            cnt_q    <= period_in - {{(`SDF_CNT_W-1){1'b0}}, 1'b1};
            tick_out <= 1'b1;
        end else begin
            cnt_q    <= cnt_q - {{(`SDF_CNT_W-1){1'b0}}, 1'b1};
            tick_out <= 1'b0;
        end
    end
endmodule

/* File: sdf_skid_buf.v */
// sdf_skid_buf.v: two-entry buffer with valid/ready on both sides
// assumes a single clock; word is lost if both entries are full, or if it arrives with a flush
`timescale 1ns/1ns
`include "sdf_map.vh"
module sdf_skid_buf (
    input  wire                   mclk_in,
    input  wire                   arst_n_in,
    input  wire                   flush_in,
    input  wire                   in_valid_in,
    input  wire [`SDF_DATA_W-1:0] in_data_in,
    output wire                   in_ready_out,
    output reg                    out_valid_out,
    output reg  [`SDF_DATA_W-1:0] out_data_out,
    input  wire                   out_ready_in
);
    reg [`SDF_DATA_W-1:0] mem_q [0:1];
    reg                   wp_q;
    reg                   rp_q;
    reg [1:0]             cnt_q;
    wire                  push;
    wire                  pop;
    assign in_ready_out = (cnt_q != 2'h2);
    assign push = in_valid_in && in_ready_out;
    assign pop  = out_valid_out && out_ready_in;
    // pointers and count; the head word is mirrored into registered outputs
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wp_q          <= 1'b0;
            rp_q          <= 1'b0;
            cnt_q         <= 2'h0;
            out_valid_out <= 1'b0;
            out_data_out  <= {`SDF_DATA_W{1'b0}};
        end else if (flush_in) begin
            wp_q          <= 1'b0;
            rp_q          <= 1'b0;
            cnt_q         <= 2'h0;
            out_valid_out <= 1'b0;
        end else begin
            if (push) begin
                mem_q[wp_q] <= in_data_in;
                wp_q        <= ~wp_q;
            end
            if (pop)
                rp_q <= ~rp_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
            // head after this cycle
            if (pop) begin
                if (cnt_q == 2'h2) begin
                    out_valid_out <= 1'b1;
                    out_data_out  <= mem_q[~rp_q];
                end else if (push) begin
                    out_valid_out <= 1'b1;
                    out_data_out  <= in_data_in;
                end else begin
                    out_valid_out <= 1'b0;
                end
            end else if (cnt_q == 2'h0 && push) begin
                out_valid_out <= 1'b1;
                out_data_out  <= in_data_in;
            end
        end
    end
endmodule

/* File: sdf_rate_ctrl.v */
// sdf_rate_ctrl.v: third_order_select/sinc4 decimation rate and settling control, chop off
// assumes a 1-bit modulator stream on a pin, synchronised here; one clock
// Operation
// - mode bit 11 selects zero latency
// - zero latency: every result fully settled unless a step lands mid-conversion
// - sinc4 zero latency period 4x1024xrate
// - third_order_select zero latency period 3x1024xrate
// - rate 1..1023; normal period 1024xrate
// - select bit 1 third_order_select, 0 sinc4
// - third_order_select normal settles in three periods
// - channel change resets, withholds until settled
// - step: keep rate, flag unsettled results
// - zero latency async step: one unsettled
// - zero latency constant rate on change
// - dual notch at rate 96 alters response; here only sinc4 results, third_order_select results unchanged
// - sinc4, 480: 10 Hz or 2.5 Hz
// - third_order_select, 96: 50 Hz or 16.7 Hz
// - reset default sinc4, chop off
// - sinc4 normal 1024xrate, four-period settling
`timescale 1ns/1ns
`include "sdf_map.vh"
module sdf_rate_ctrl (
    input  wire                   mclk_in,
    input  wire                   arst_n_in,
    input  wire                   mod_bit_in,
    input  wire [`SDF_MODE_W-1:0] mode_word_in,
    input  wire [`SDF_RATE_W-1:0] output_rate_word_in,
    input  wire                   third_order_select_in,
    input  wire                   dual_notch_enable_in,
    input  wire                   channel_change_in,
    input  wire                   input_step_in,
    input  wire                   result_ready_in,
    output reg                    result_valid_out,
    output reg  [`SDF_DATA_W-1:0] result_data_out,
    output reg                    result_settled_out,
    output reg                    conv_strobe_out,
    output reg                    rate_error_out,
    output reg                    notch_active_out,
    output reg                    overrun_out
);
    // modulator pin crosses in through two flops
    reg        mod_s1_q;
    reg        mod_s2_q;
    // configuration seen last cycle, for restart detection
    reg [`SDF_RATE_W-1:0] rate_q;
    reg        sel3_q;
    reg        zl_q;
    reg        cfg_init_q;
    // settling bookkeeping
    reg [2:0]  settle_q;
    reg [2:0]  dirty_q;
    reg [`SDF_ACC_W-1:0] acc_q [0:3];
    reg [`SDF_DEC_W-1:0] phase_q;
    reg        push_q;
    reg [`SDF_DATA_W-1:0] push_data_q;
    wire       zero_lat;
    wire [2:0] order;
    wire       cfg_change;
    wire       restart;
    wire       tick;
    wire       buf_ready;
    wire       buf_valid;
    wire [`SDF_DATA_W-1:0] buf_data;
    wire [`SDF_CNT_W-1:0]  period;
    wire       rate_ok;
    wire       notch;
    integer    i;

    // order decode, used for both period and settling count
    function [2:0] order_of;
        input sel3;
        begin
            if (sel3)
                order_of = `SDF_ORDER3;
            else
                order_of = `SDF_ORDER4;
        end
    endfunction

    assign zero_lat   = mode_word_in[`SDF_ZERO_LAT_BIT];
    assign order      = order_of(third_order_select_in);
    assign rate_ok    = (output_rate_word_in >= `SDF_RATE_MIN);
    // dual notch at the documented rate word; modelled as a shaped comb
    assign notch      = dual_notch_enable_in && (output_rate_word_in == `SDF_NOTCH_RATE);
    assign cfg_change = cfg_init_q && ((rate_q != output_rate_word_in) ||
                        (sel3_q != third_order_select_in) || (zl_q != zero_lat));
    assign restart    = !cfg_init_q || cfg_change || channel_change_in || !rate_ok;
    // zero latency stretches one period to the whole settling time
    assign period = zero_lat ?
        ({{(`SDF_CNT_W-3){1'b0}}, order} * {{(`SDF_CNT_W-`SDF_RATE_W){1'b0}}, output_rate_word_in}
         * {{(`SDF_CNT_W-`SDF_DEC_W){1'b0}}, `SDF_DEC_BASE}) :
        ({{(`SDF_CNT_W-`SDF_RATE_W){1'b0}}, output_rate_word_in}
         * {{(`SDF_CNT_W-`SDF_DEC_W){1'b0}}, `SDF_DEC_BASE});

    // divider gives the conversion tick
    sdf_period_div sdf_period_div_i (
        .mclk_in    (mclk_in),
        .arst_n_in  (arst_n_in),
        .restart_in (restart),
        .period_in  (period),
        .tick_out   (tick)
    );

    // results pass a two-entry buffer; a stall past two results loses the next one and raises overrun_out
    sdf_skid_buf sdf_skid_buf_i (
        .mclk_in       (mclk_in),
        .arst_n_in     (arst_n_in),
        .flush_in      (channel_change_in),
        .in_valid_in   (push_q),
        .in_data_in    (push_data_q),
        .in_ready_out  (buf_ready),
        .out_valid_out (buf_valid),
        .out_data_out  (buf_data),
        .out_ready_in  (result_ready_in)
    );

    // synchroniser; only the second flop feeds the filter
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mod_s1_q <= 1'b0;
            mod_s2_q <= 1'b0;
        end else begin
            mod_s1_q <= mod_bit_in;
            mod_s2_q <= mod_s1_q;
        end
    end

    // configuration shadow
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rate_q     <= {`SDF_RATE_W{1'b0}};
            sel3_q     <= 1'b0;
            zl_q       <= 1'b0;
            cfg_init_q <= 1'b0;
        end else begin
            rate_q     <= output_rate_word_in;
            sel3_q     <= third_order_select_in;
            zl_q       <= zero_lat;
            cfg_init_q <= 1'b1;
        end
    end

    // cascade of integrators, cleared on restart; a cheap stand-in for the
    // full sinc datapath, kept so the timing stays visible in results
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (i = 0; i < 4; i = i + 1)
                acc_q[i] <= {`SDF_ACC_W{1'b0}};
            phase_q <= {`SDF_DEC_W{1'b0}};
        end else if (restart || tick) begin
            for (i = 0; i < 4; i = i + 1)
                acc_q[i] <= {`SDF_ACC_W{1'b0}};
            phase_q <= {`SDF_DEC_W{1'b0}};
        end else begin
            acc_q[0] <= acc_q[0] + {{(`SDF_ACC_W-1){1'b0}}, mod_s2_q};
            acc_q[1] <= acc_q[1] + acc_q[0];
            acc_q[2] <= acc_q[2] + acc_q[1];
            // the notch option folds in a second comb term
            acc_q[3] <= notch ? (acc_q[3] + acc_q[2] - acc_q[0]) : (acc_q[3] + acc_q[2]);
            phase_q  <= phase_q + {{(`SDF_DEC_W-1){1'b0}}, 1'b1};
        end
    end

    // settling: after restart, withhold order-1 ticks (normal) or none (zl)
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            settle_q    <= 3'h0;
            dirty_q     <= 3'h0;
            push_q      <= 1'b0;
            push_data_q <= {`SDF_DATA_W{1'b0}};
        end else begin
            push_q <= 1'b0;
            if (restart) begin
                settle_q <= zero_lat ? 3'h0 : (order - 3'h1);
                dirty_q  <= 3'h0;
            end else if (tick) begin
                if (settle_q != 3'h0) begin
                    settle_q <= settle_q - 3'h1;
                end else begin
                    push_q      <= 1'b1;
                    push_data_q <= third_order_select_in ? acc_q[2][`SDF_ACC_W-1:`SDF_ACC_W-`SDF_DATA_W]
                                                         : acc_q[3][`SDF_ACC_W-1:`SDF_ACC_W-`SDF_DATA_W];
                end
                // step on a boundary: the set wins over this tick's decrement;
                // a zero latency period spans the whole settling time, so such a step costs none
                if (input_step_in && !zero_lat)
                    dirty_q <= order;
                else if (dirty_q != 3'h0)
                    dirty_q <= dirty_q - 3'h1;
            end else if (input_step_in) begin
                // mid-conversion step costs one more result; in zero latency the
                // coming tick decrements first, so exactly one result is flagged
                dirty_q <= zero_lat ? 3'h2 : (order + 3'h1);
            end
        end
    end

    // registered outputs
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            result_valid_out   <= 1'b0;
            result_data_out    <= {`SDF_DATA_W{1'b0}};
            result_settled_out <= 1'b1;
            conv_strobe_out    <= 1'b0;
            rate_error_out     <= 1'b0;
            notch_active_out   <= 1'b0;
            overrun_out        <= 1'b0;
        end else begin
            result_valid_out   <= buf_valid;
            result_data_out    <= buf_data;
            result_settled_out <= (dirty_q == 3'h0);
            conv_strobe_out    <= tick && !restart;
            rate_error_out     <= !rate_ok;
            notch_active_out   <= notch;
            overrun_out        <= push_q && !buf_ready;
        end
    end
endmodule

/* File: sdf_rate_ctrl_monitor.sv */
// sdf_rate_ctrl_monitor.sv: port timing checks for the rate controller
// assumes one clock; a setting change restarts the design as a channel change does
`timescale 1ns/1ns
module sdf_rate_ctrl_monitor (
    input wire logic        mclk_in,
    input wire logic        arst_n_in,
    input wire logic        mod_bit_in,
    input wire logic [11:0] mode_word_in,
    input wire logic [9:0]  output_rate_word_in,
    input wire logic        third_order_select_in,
    input wire logic        dual_notch_enable_in,
    input wire logic        channel_change_in,
    input wire logic        input_step_in,
    input wire logic        result_ready_in,
    input wire logic        result_valid_out,
    input wire logic [23:0] result_data_out,
    input wire logic        result_settled_out,
    input wire logic        conv_strobe_out,
    input wire logic        rate_error_out,
    input wire logic        notch_active_out,
    input wire logic        overrun_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    logic [31:0] gap_q;
    logic [31:0] need_p;
    logic [2:0]  nstr_q;
    logic [2:0]  need_s;
    logic        seen_q;
    logic        rst_c;
    logic [22:0] cfg_q;
    // a mode, rate or order select change restarts, so gaps and settle counts start over
    assign rst_c = channel_change_in || (cfg_q != {mode_word_in, output_rate_word_in, third_order_select_in});
    assign need_p = {22'h0, output_rate_word_in} * 32'h400
                    * (mode_word_in[11] ? (third_order_select_in ? 32'h3 : 32'h4) : 32'h1);
    assign need_s = mode_word_in[11] ? 3'h1 : (third_order_select_in ? 3'h3 : 3'h4);
    // gap since last strobe and strobes since restart, saturating at 7
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cfg_q <= 23'h0;
            gap_q <= 32'h0;
            nstr_q <= 3'h0;
            seen_q <= 1'b0;
        end else begin
            cfg_q <= {mode_word_in, output_rate_word_in, third_order_select_in};
            gap_q <= (rst_c || conv_strobe_out) ? 32'h0 : gap_q + 32'h1;
            seen_q <= !rst_c && (seen_q || conv_strobe_out);
            nstr_q <= rst_c ? 3'h0 : nstr_q + {2'h0, conv_strobe_out && nstr_q != 3'h7};
        end
    end
    strobe_single_a: assert property (conv_strobe_out |=> !conv_strobe_out)
        else $error("strobe longer than one cycle");
    period_exact_a: assert property (conv_strobe_out && seen_q && !rst_c |-> gap_q == need_p - 32'h1)
        else $error("conversion period wrong");
    settle_first_a: assert property ($rose(result_valid_out) |-> nstr_q >= need_s)
        else $error("result before settling");
    rate_zero_a: assert property ((output_rate_word_in == 10'h0)[*3] |-> rate_error_out)
        else $error("zero rate not flagged");
    zero_quiet_a: assert property (rate_error_out |-> !conv_strobe_out)
        else $error("strobe with zero rate");
    notch_on_a: assert property ((dual_notch_enable_in && output_rate_word_in == 10'h060)[*3]
        |-> notch_active_out)
        else $error("dual notch not in use");
    notch_off_a: assert property ((!(dual_notch_enable_in && output_rate_word_in == 10'h060))[*3]
        |-> !notch_active_out)
        else $error("dual notch in use wrongly");
    hold_result_a: assert property (result_valid_out && !result_ready_in && !$past(result_ready_in)
        && !channel_change_in && !$past(channel_change_in) |=> result_valid_out && $stable(result_data_out))
        else $error("result dropped while stalled");
    cover property (mode_word_in[11] && conv_strobe_out);
    cover property (overrun_out);
    cover property (result_valid_out && !result_settled_out);
endmodule
bind sdf_rate_ctrl sdf_rate_ctrl_monitor sdf_rate_ctrl_monitor_i (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .mod_bit_in(mod_bit_in), .mode_word_in(mode_word_in), .output_rate_word_in(output_rate_word_in),
    .third_order_select_in(third_order_select_in), .dual_notch_enable_in(dual_notch_enable_in),
    .channel_change_in(channel_change_in), .input_step_in(input_step_in), .result_ready_in(result_ready_in),
    .result_valid_out(result_valid_out), .result_data_out(result_data_out), .result_settled_out(result_settled_out),
    .conv_strobe_out(conv_strobe_out), .rate_error_out(rate_error_out), .notch_active_out(notch_active_out),
    .overrun_out(overrun_out));

/* File: sdf_far_model.sv */
// sdf_far_model.sv: modulator bit source and result sink
// assumes the bench steers stalls; bitstream is a fixed lfsr pattern
`timescale 1ns/1ns
module sdf_far_model (
    input  wire logic mclk_in,
    input  wire logic arst_n_in,
    input  wire logic stall_in,
    output wire logic mod_bit_out,
    output wire logic ready_out
);
    logic [7:0] lfsr_q;
    // busy bitstream so the integrators never sit on a constant
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lfsr_q <= 8'h5a;
        end else begin
            lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        end
    end
    assign mod_bit_out = lfsr_q[0];
    assign ready_out = !stall_in;  // sink refuses only when told
endmodule

/* File: sdf_rate_ctrl_tb_top.sv */
// sdf_rate_ctrl_tb_top.sv: directed bench for the decimation rate controller
// assumes the far model for bitstream and ready; rate word 1 keeps runs short
`timescale 1ns/1ns
module sdf_rate_ctrl_tb_top;
    logic        mclk_in = 1'b0;
    logic        arst_n_in = 1'b0;
    logic [11:0] mode_w = 12'h000;
    logic [9:0]  rate_w = 10'h001;
    logic        sel3 = 1'b0, notch = 1'b0, chan = 1'b0, step = 1'b0, stall = 1'b0;
    wire         mod_bit, ready, valid, settled, strobe, rerr, nact, ovr;
    wire  [23:0] data;
    integer      num_errors = 0, checks = 0, i, ns_v, nu_v, cy_v, no_v;
    sdf_far_model sdf_far_model_i (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .stall_in(stall),
        .mod_bit_out(mod_bit), .ready_out(ready));
    sdf_rate_ctrl sdf_rate_ctrl_i (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .mod_bit_in(mod_bit),
        .mode_word_in(mode_w), .output_rate_word_in(rate_w), .third_order_select_in(sel3),
        .dual_notch_enable_in(notch), .channel_change_in(chan), .input_step_in(step), .result_ready_in(ready),
        .result_valid_out(valid), .result_data_out(data), .result_settled_out(settled), .conv_strobe_out(strobe),
        .rate_error_out(rerr), .notch_active_out(nact), .overrun_out(ovr));
    always #5 mclk_in = ~mclk_in;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        if (num_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // setting plus channel change, so a stale result cannot straddle it
    task automatic cfg(input logic zl, input logic s3, input logic [9:0] r);
        @(negedge mclk_in);
        mode_w = {zl, 11'h000};
        sel3 = s3;
        rate_w = r;
        chan = 1'b1;
        @(negedge mclk_in);
        chan = 1'b0;
    endtask
    // counts strobes, unsettled results and overruns until n results or lim cycles;
    // n of 99 only watches for lim cycles, any other shortfall fails the result-count check
    task automatic run(input integer n, input integer lim, output integer ns, output integer nu,
                       output integer cy, output integer no);
        integer nr;
        logic   pv;
        nr = 0; ns = 0; nu = 0; cy = 0; no = 0; pv = valid;
        while (nr < n && cy < lim) begin
            @(negedge mclk_in);
            cy = cy + 1;
            ns = ns + strobe;
            no = no + ovr;
            if (valid === 1'b1 && pv !== 1'b1) begin
                nr = nr + 1;
                nu = nu + (settled !== 1'b1);
            end
            pv = valid;
        end
        if (n != 99)
            chk(nr, n);
    endtask
    task automatic step_mid;
        repeat (500) @(negedge mclk_in);
        step = 1'b1;
        @(negedge mclk_in);
        step = 1'b0;
    endtask
    task automatic notch_case(input logic n, input logic [9:0] r, input logic e);
        @(negedge mclk_in);
        notch = n;
        rate_w = r;
        repeat (4) @(negedge mclk_in);
        chk(nact, e);
    endtask
    initial begin
        #950000;
        num_errors = num_errors + 1;
        report_and_stop;
    end
    initial begin
        repeat (10) @(negedge mclk_in);
        arst_n_in = 1'b1;
        chk({valid, strobe, settled, ovr, rerr, nact}, 32'h8);
        // all four order and latency combinations at rate 1
        for (i = 0; i < 4; i = i + 1) begin
            cfg(i[1], i[0], 10'h001);
            run(1, 30000, ns_v, nu_v, cy_v, no_v);
            chk(ns_v, i[1] ? 1 : (i[0] ? 3 : 4));
            run(1, 30000, ns_v, nu_v, cy_v, no_v);
            chk(cy_v, (i[1] ? (i[0] ? 3 : 4) : 1) * 1024);
        end
        // setting change alone, with no channel change, must restart the count
        @(negedge mclk_in);
        mode_w = 12'h000;
        rate_w = 10'h002;
        run(2, 30000, ns_v, nu_v, cy_v, no_v);
        chk(cy_v > 6000, 1);
        run(1, 30000, ns_v, nu_v, cy_v, no_v);
        chk(cy_v, 2048);
        // mid-conversion step: the fourth result is settled, one unsettled with zero latency
        cfg(1'b0, 1'b1, 10'h001);
        run(1, 5000, ns_v, nu_v, cy_v, no_v);
        step_mid;
        run(6, 9000, ns_v, nu_v, cy_v, no_v);
        chk(nu_v, 3);
        cfg(1'b1, 1'b0, 10'h001);
        run(1, 5000, ns_v, nu_v, cy_v, no_v);
        chk(nu_v, 0);
        step_mid;
        run(3, 15000, ns_v, nu_v, cy_v, no_v);
        chk(nu_v, 1);
        // stalled sink fills the buffer, then drains once released
        cfg(1'b0, 1'b1, 10'h001);
        run(1, 5000, ns_v, nu_v, cy_v, no_v);
        stall = 1'b1;
        run(99, 7000, ns_v, nu_v, cy_v, no_v);
        chk(no_v != 0, 1);
        stall = 1'b0;
        run(1, 3000, ns_v, nu_v, cy_v, no_v);
        chk(cy_v < 3000, 1);
        cfg(1'b0, 1'b1, 10'h000);
        run(99, 1100, ns_v, nu_v, cy_v, no_v);
        chk({ns_v == 0, rerr}, 32'h3);
        notch_case(1'b1, 10'h060, 1'b1);
        notch_case(1'b1, 10'h061, 1'b0);
        notch_case(1'b0, 10'h060, 1'b0);
        // reset in mid-run: idle outputs, then a fresh sinc4 start at rate 1
        arst_n_in = 1'b0;
        sel3 = 1'b0;
        rate_w = 10'h001;
        repeat (2) @(negedge mclk_in);
        chk({valid, strobe, settled, ovr, rerr, nact}, 32'h8);
        arst_n_in = 1'b1;
        run(1, 5000, ns_v, nu_v, cy_v, no_v);
        chk(ns_v, 4);
        report_and_stop;
    end
endmodule
